// [hdl/sqg_top.v]
// Purpose: button driven rule guessing game with LEDs and two digits
// Assumes: buttons and polarity are asynchronous pins, active high
// Notes: colours red 0, green 1, blue 2, yellow 3; two bits per entry
`timescale 1ns/1ps
`include "sqg_regs.vh"
module sqg_top #(
  parameter [23:0] DEB_CYC = `SQG_DEB_CYC,
  parameter [23:0] LONG_CYC = `SQG_LONG_CYC,
  parameter [23:0] FLASH_CYC = `SQG_FLASH_CYC,
  parameter [23:0] MUX_CYC = `SQG_MUX_CYC,
  parameter [23:0] TONE_CYC = `SQG_TONE_CYC
) (
  input wire ref_clk,
  input wire nrst,
  input wire btn_red,
  input wire btn_green,
  input wire btn_blue,
  input wire btn_yellow,
  input wire disp_pol,
  output reg led_red,
  output reg led_green,
  output reg led_yellow,
  output reg led_blue,
  output reg speaker,
  output reg digit1,
  output reg digit2,
  output reg [6:0] seg,
  output wire [6:0] seg_oe
);
  localparam [1:0] ST_EXP = 2'd0;
  localparam [1:0] ST_GEN = 2'd1;
  localparam [1:0] ST_SHOW = 2'd2;
  localparam [1:0] ST_CHAL = 2'd3;

  // Hidden rule of each level
  function sqg_rule;
    input [4:0] lvl;
    input [13:0] sq;
    input [2:0] len;
    reg [2:0] c0, c1, c2, c3, dn;
    reg [1:0] fst, lst, prv, cc;
    reg adj, adjr, pal, r;
    integer i, k;
    begin
      c0 = 3'd0; c1 = 3'd0; c2 = 3'd0; c3 = 3'd0;
      fst = sq[1:0]; lst = 2'd0; prv = 2'd0;
      adj = 1'b0; adjr = 1'b0; pal = 1'b1; r = 1'b0;
      for (i = 0; i < 7; i = i + 1) begin
        if (i < len) begin
          cc = sq[2*i +: 2];
          case (cc)
            2'd0: c0 = c0 + 3'd1;
            2'd1: c1 = c1 + 3'd1;
            2'd2: c2 = c2 + 3'd1;
            default: c3 = c3 + 3'd1;
          endcase
          if (i > 0 && cc == prv) adj = 1'b1;
          if (i > 0 && cc == prv && cc == `SQG_C_RED) adjr = 1'b1;
          k = len;
          k = 2 * (k - 1 - i);
          if (cc != sq[k +: 2]) pal = 1'b0;
          prv = cc;
          lst = cc;
        end
      end
      dn = {2'b00, c0 != 3'd0} + {2'b00, c1 != 3'd0} +
           {2'b00, c2 != 3'd0} + {2'b00, c3 != 3'd0};
      case (lvl)
        5'd0: r = c0 != 3'd0;
        5'd1: r = fst == `SQG_C_GREEN;
        5'd2: r = lst == `SQG_C_BLUE;
        5'd3: r = c3 == 3'd2;
        5'd4: r = ~len[0];
        5'd5: r = c2 == 3'd0;
        5'd6: r = fst == lst;
        5'd7: r = c0 > c1;
        5'd8: r = len <= 3'd3;
        5'd9: r = dn == 3'd1;
        5'd10: r = c1[0];
        5'd11: r = c0 != 3'd0 && c2 != 3'd0;
        5'd12: r = fst != `SQG_C_RED && lst != `SQG_C_RED;
        5'd13: r = adj;
        5'd14: r = c3 == c2;
        5'd15: r = dn == 3'd2;
        5'd16: r = c1 >= 3'd3;
        5'd17: r = len >= 3'd2 && sq[3:2] == `SQG_C_BLUE;
        5'd18: r = pal;
        default: r = ~adjr;
      endcase
      sqg_rule = (len != 3'd0) && r;
    end
  endfunction

  // Seven segment font, bit 0 is segment A
  function [6:0] sqg_font;
    input [3:0] d;
    begin
      case (d)
        4'd0: sqg_font = 7'h3f;
        4'd1: sqg_font = 7'h06;
        4'd2: sqg_font = 7'h5b;
        4'd3: sqg_font = 7'h4f;
        4'd4: sqg_font = 7'h66;
        4'd5: sqg_font = 7'h6d;
        4'd6: sqg_font = 7'h7d;
        4'd7: sqg_font = 7'h07;
        4'd8: sqg_font = 7'h7f;
        4'd9: sqg_font = 7'h6f;
        default: sqg_font = 7'h00;
      endcase
    end
  endfunction

  wire [3:0] btn_raw = {btn_yellow, btn_blue, btn_green, btn_red};
  wire [3:0] btn_db;
  assign seg_oe = 7'h7f;

  // Per button three-flop sync and stability filter
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_btn
      reg [2:0] sy_reg;
      reg [23:0] dc_reg;
      reg st_reg;
      always @(posedge ref_clk) begin
        if (!nrst) begin
          sy_reg <= 3'h0;
          dc_reg <= 24'h0;
          st_reg <= 1'b0;
        end else begin
          sy_reg <= {sy_reg[1:0], btn_raw[gi]};
          if (sy_reg[1] != sy_reg[2] || sy_reg[2] == st_reg) begin
            dc_reg <= 24'h0;
          end else if (dc_reg >= DEB_CYC - 24'h1) begin
            st_reg <= sy_reg[2];
            dc_reg <= 24'h0;
          end else begin
            dc_reg <= dc_reg + 24'h1;
          end
        end
      end
      assign btn_db[gi] = st_reg;
    end
  endgenerate

  // Press gathering: event fires when every button is released
  reg [3:0] pm_reg, evm_reg;
  reg [23:0] hold_reg;
  reg ev_reg, evl_reg;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      pm_reg <= 4'h0;
      evm_reg <= 4'h0;
      hold_reg <= 24'h0;
      ev_reg <= 1'b0;
      evl_reg <= 1'b0;
    end else begin
      ev_reg <= 1'b0;
      if (btn_db != 4'h0) begin
        pm_reg <= pm_reg | btn_db;
        if (hold_reg != 24'hffffff) hold_reg <= hold_reg + 24'h1;
      end else if (pm_reg != 4'h0) begin
        ev_reg <= 1'b1;
        evm_reg <= pm_reg;
        evl_reg <= hold_reg >= LONG_CYC;
        pm_reg <= 4'h0;
        hold_reg <= 24'h0;
      end
    end
  end

  wire sh = ev_reg & ~evl_reg;
  wire lg = ev_reg & evl_reg;
  wire m_r = evm_reg == `SQG_M_RED;
  wire m_g = evm_reg == `SQG_M_GREEN;
  wire m_b = evm_reg == `SQG_M_BLUE;
  wire m_y = evm_reg == `SQG_M_YELLOW;
  wire m_gy = evm_reg == (`SQG_M_GREEN | `SQG_M_YELLOW);
  wire m_rb = evm_reg == (`SQG_M_RED | `SQG_M_BLUE);
  wire m_by = evm_reg == (`SQG_M_BLUE | `SQG_M_YELLOW);
  wire m_rg = evm_reg == (`SQG_M_RED | `SQG_M_GREEN);
  wire m_gbc = evm_reg == (`SQG_M_GREEN | `SQG_M_BLUE);
  wire m_ry = evm_reg == (`SQG_M_RED | `SQG_M_YELLOW);
  wire [1:0] ev_col = {evm_reg[3] | evm_reg[2], evm_reg[3] | evm_reg[1]};

  reg [1:0] st_reg;
  reg [4:0] lvl_reg;
  reg [13:0] buf_reg, q_reg, pl_reg;
  reg [2:0] blen_reg, qlen_reg, plen_reg, pidx_reg;
  reg [3:0] notch_reg;
  reg chal_reg, snd_reg, qwant_reg, gwant_reg, gchal_reg, pon_reg;
  reg [23:0] ft_reg, lfsr_reg;

  // Random candidate, lengths 1 to 6 only
  wire [2:0] cl = lfsr_reg[23:21];
  wire [13:0] cand = {2'b00, lfsr_reg[11:0]};
  wire cand_ok = cl != 3'd0 && cl <= `SQG_Q_MAX &&
                 sqg_rule(lvl_reg, cand, cl) == gwant_reg;
  wire cur_valid = sqg_rule(lvl_reg, buf_reg, blen_reg);

  task start_show;
    input [13:0] s;
    input [2:0] l;
    begin
      pl_reg <= s;
      plen_reg <= l;
      pidx_reg <= 3'd0;
      pon_reg <= 1'b1;
      ft_reg <= 24'h0;
      st_reg <= ST_SHOW;
    end
  endtask

  task go_level;
    input [4:0] l;
    begin
      lvl_reg <= l;
      buf_reg <= 14'h0;
      blen_reg <= 3'd0;
      notch_reg <= 4'd0;
      chal_reg <= 1'b0;
      st_reg <= ST_EXP;
    end
  endtask

  task new_q;
    begin
      gwant_reg <= lfsr_reg[0];
      gchal_reg <= 1'b1;
      st_reg <= ST_GEN;
    end
  endtask

  task add_notch;
    input ask;
    begin
      if (notch_reg == `SQG_NOTCH_WIN - 4'd1) begin
        go_level(lvl_reg == `SQG_LVL_LAST ? lvl_reg : lvl_reg + 5'd1);
      end else begin
        notch_reg <= notch_reg + 4'd1;
        if (ask) new_q;
      end
    end
  endtask

  // Game state machine
  always @(posedge ref_clk) begin
    if (!nrst) begin
      go_level(`SQG_LVL_RST);
      snd_reg <= 1'b1;
      q_reg <= 14'h0;
      qlen_reg <= 3'd0;
      qwant_reg <= 1'b0;
      gwant_reg <= 1'b0;
      gchal_reg <= 1'b0;
      pl_reg <= 14'h0;
      plen_reg <= 3'd0;
      pidx_reg <= 3'd0;
      pon_reg <= 1'b0;
      ft_reg <= 24'h0;
      lfsr_reg <= `SQG_LFSR_RST;
    end else begin
      lfsr_reg <= {lfsr_reg[22:0], lfsr_reg[23] ^ lfsr_reg[22] ^
                   lfsr_reg[21] ^ lfsr_reg[16]};
      if (sh && m_gbc && (st_reg == ST_EXP || st_reg == ST_CHAL))
        snd_reg <= ~snd_reg;
      case (st_reg)
        ST_EXP: begin
          if (sh && (m_r || m_g || m_b || m_y)) begin
            if (blen_reg < `SQG_BUF_MAX) begin
              buf_reg[2*blen_reg +: 2] <= ev_col;
              blen_reg <= blen_reg + 3'd1;
            end
          end else if (lg && m_r) begin
            blen_reg <= 3'd0;
          end else if (lg && m_y) begin
            if (blen_reg != 3'd0) blen_reg <= blen_reg - 3'd1;
          end else if (lg && m_b) begin
            start_show(buf_reg, blen_reg);
          end else if (lg && m_g) begin
            notch_reg <= 4'd0;
            chal_reg <= 1'b1;
            new_q;
          end else if (sh && (m_gy || m_rb)) begin
            gwant_reg <= m_gy;
            gchal_reg <= 1'b0;
            st_reg <= ST_GEN;
          end else if (sh && m_by) begin
            if (lvl_reg != `SQG_LVL_LAST) go_level(lvl_reg + 5'd1);
          end else if (sh && m_rg) begin
            if (lvl_reg != 5'd0) go_level(lvl_reg - 5'd1);
          end
        end
        ST_GEN: begin
          if (cand_ok) begin
            if (gchal_reg) begin
              q_reg <= cand;
              qlen_reg <= cl;
              qwant_reg <= gwant_reg;
            end else begin
              buf_reg <= cand;
              blen_reg <= cl;
            end
            start_show(cand, cl);
          end
        end
        ST_SHOW: begin
          if (plen_reg == 3'd0) begin
            st_reg <= chal_reg ? ST_CHAL : ST_EXP;
          end else if (ft_reg >= FLASH_CYC - 24'h1) begin
            ft_reg <= 24'h0;
            if (pon_reg) begin
              pon_reg <= 1'b0;
            end else if (pidx_reg + 3'd1 >= plen_reg) begin
              st_reg <= chal_reg ? ST_CHAL : ST_EXP;
            end else begin
              pidx_reg <= pidx_reg + 3'd1;
              pon_reg <= 1'b1;
            end
          end else begin
            ft_reg <= ft_reg + 24'h1;
          end
        end
        default: begin
          if (ev_reg && m_b) begin
            start_show(q_reg, qlen_reg);
          end else if (sh && (m_g || m_r)) begin
            if (m_g == qwant_reg) begin
              add_notch(1'b1);
            end else begin
              chal_reg <= 1'b0;
              st_reg <= ST_EXP;
            end
          end else if (sh && m_ry) begin
            chal_reg <= 1'b0;
            st_reg <= ST_EXP;
          end else if (sh && m_by) begin
            add_notch(1'b0);
          end else if (sh && m_rg) begin
            if (notch_reg != 4'd0) notch_reg <= notch_reg - 4'd1;
          end
        end
      endcase
    end
  end

  // Display digits: level in decimal or notch bar
  wire [4:0] lvl_n = lvl_reg + 5'd1;
  wire [4:0] ones = lvl_n >= 5'd20 ? lvl_n - 5'd20 :
                    lvl_n >= 5'd10 ? lvl_n - 5'd10 : lvl_n;
  wire [3:0] tens = lvl_n >= 5'd20 ? 4'd2 : lvl_n >= 5'd10 ? 4'd1 : 4'd15;
  wire [14:0] bar = (15'h1 << notch_reg) - 15'h1;
  wire [6:0] left = chal_reg ? bar[6:0] : sqg_font(tens);
  wire [6:0] right = chal_reg ? bar[13:7] : sqg_font(ones[3:0]);
  wire [1:0] show_col = pl_reg[2*pidx_reg +: 2];
  wire shon = st_reg == ST_SHOW && pon_reg && plen_reg != 3'd0;

  reg [2:0] pol_sy_reg;
  reg pol_reg, dsel_reg, tone_reg;
  reg [23:0] mux_reg, tc_reg;
  // Outputs, polarity filter, multiplex and tone timers
  always @(posedge ref_clk) begin
    if (!nrst) begin
      pol_sy_reg <= 3'h0;
      pol_reg <= 1'b0;
      dsel_reg <= 1'b0;
      tone_reg <= 1'b0;
      mux_reg <= 24'h0;
      tc_reg <= 24'h0;
      led_red <= 1'b0;
      led_green <= 1'b0;
      led_yellow <= 1'b0;
      led_blue <= 1'b0;
      speaker <= 1'b0;
      digit1 <= 1'b0;
      digit2 <= 1'b0;
      seg <= 7'h00;
    end else begin
      pol_sy_reg <= {pol_sy_reg[1:0], disp_pol};
      if (pol_sy_reg[1] == pol_sy_reg[2]) pol_reg <= pol_sy_reg[2];
      if (mux_reg >= MUX_CYC - 24'h1) begin
        mux_reg <= 24'h0;
        dsel_reg <= ~dsel_reg;
      end else begin
        mux_reg <= mux_reg + 24'h1;
      end
      if (tc_reg >= TONE_CYC - 24'h1) begin
        tc_reg <= 24'h0;
        tone_reg <= ~tone_reg;
      end else begin
        tc_reg <= tc_reg + 24'h1;
      end
      seg <= (dsel_reg ? right : left) ^ {7{pol_reg}};
      digit1 <= ~dsel_reg ^ pol_reg;
      digit2 <= dsel_reg ^ pol_reg;
      speaker <= snd_reg & tone_reg & (shon | (btn_db != 4'h0));
      if (shon) begin
        led_red <= show_col == `SQG_C_RED;
        led_green <= show_col == `SQG_C_GREEN;
        led_blue <= show_col == `SQG_C_BLUE;
        led_yellow <= show_col == `SQG_C_YELLOW;
      end else if (st_reg == ST_EXP) begin
        led_red <= blen_reg != 3'd0 && !cur_valid;
        led_green <= cur_valid;
        led_blue <= blen_reg == 3'd0;
        led_yellow <= blen_reg == `SQG_BUF_MAX;
      end else begin
        led_red <= 1'b0;
        led_green <= 1'b0;
        led_blue <= 1'b0;
        led_yellow <= 1'b0;
      end
    end
  end
endmodule // sqg_top

// [hdl/sqg_regs.vh]
// Purpose: constants for the sequence rule guessing game
// Assumes: one 20 MHz clock; all times scaled from it
// Notes: counts above 4096 cycles are defaults of top-level parameters
`ifndef SQG_REGS_VH
`define SQG_REGS_VH
`define SQG_CLK_HZ 20000000
`define SQG_DEB_MS 10
`define SQG_DEB_CYC 24'd200000
`define SQG_LONG_MS 400
`define SQG_LONG_CYC 24'd8000000
`define SQG_FLASH_MS 200
`define SQG_FLASH_CYC 24'd4000000
`define SQG_MUX_MS 2
`define SQG_MUX_CYC 24'd40000
`define SQG_TONE_HZ 1000
`define SQG_TONE_CYC 24'd10000
`define SQG_LVL_RST 5'd0
`define SQG_LVL_LAST 5'd19
`define SQG_BUF_MAX 3'd7
`define SQG_Q_MAX 3'd6
`define SQG_NOTCH_WIN 4'd15
`define SQG_M_RED 4'h1
`define SQG_M_GREEN 4'h2
`define SQG_M_BLUE 4'h4
`define SQG_M_YELLOW 4'h8
`define SQG_C_RED 2'd0
`define SQG_C_GREEN 2'd1
`define SQG_C_BLUE 2'd2
`define SQG_C_YELLOW 2'd3
`define SQG_LFSR_RST 24'h000001
`endif

// [test/sqg_top_sva.sv]
// Purpose: port checks for the rule guessing game
// Assumes: short timing parameters, polarity changed rarely
// Notes: bound to every sqg_top instance
`timescale 1ns/1ps
module sqg_chk #(
  parameter [23:0] MUX_CYC = 24'd4
) (
  input wire ref_clk,
  input wire nrst,
  input wire disp_pol,
  input wire led_red,
  input wire led_green,
  input wire led_yellow,
  input wire led_blue,
  input wire digit1,
  input wire digit2,
  input wire [6:0] seg,
  input wire [6:0] seg_oe
);
  reg prev_reg = 1'b0;
  reg pol_reg = 1'b0;
  reg [23:0] run_reg = 24'd0;
  reg [3:0] calm_reg = 4'd0;
  default clocking cb @(posedge ref_clk); endclocking
  // Digit run length and quiet time since reset or polarity flip
  always @(posedge ref_clk) begin
    prev_reg <= digit1;
    pol_reg <= disp_pol;
    run_reg <= (digit1 != prev_reg) ? 24'd1 : run_reg + 24'd1;
    if (!nrst || disp_pol != pol_reg)
      calm_reg <= 4'd0;
    else if (calm_reg != 4'd15)
      calm_reg <= calm_reg + 4'd1;
  end
  AST_RST_LED: assert property (
    !nrst |=> !(led_red | led_green | led_yellow | led_blue))
    else $error("leds lit after a reset edge");
  AST_RST_DISP: assert property (
    !nrst |=> seg == 7'h00 && !digit1 && !digit2)
    else $error("display driven after a reset edge");
  AST_START: assert property (
    $rose(nrst) |-> ##[1:3] (led_blue && !led_red && !led_green
      && !led_yellow))
    else $error("blue alone not shown after reset");
  AST_DIG_ONE: assert property (disable iff (!nrst)
    $past(nrst) |-> digit1 != digit2)
    else $error("digit selects not complementary");
  AST_SEG_OE: assert property (disable iff (!nrst)
    seg_oe == 7'h7f)
    else $error("segment enables not all driving");
  AST_MUX: assert property (disable iff (!nrst)
    (digit1 != prev_reg && calm_reg >= 4'd12) |-> run_reg == MUX_CYC)
    else $error("digit swap period wrong");
  AST_RG_EXCL: assert property (disable iff (!nrst)
    !(led_red && led_green))
    else $error("valid and invalid lit together");
  AST_BLUE_ALONE: assert property (disable iff (!nrst)
    led_blue |-> !led_red && !led_green)
    else $error("validity shown with empty buffer");
  // Main scenarios reached
  cover property ($rose(led_yellow));
  cover property ($rose(led_green));
  cover property ($rose(led_red));
endmodule // sqg_chk

bind sqg_top sqg_chk #(.MUX_CYC(MUX_CYC)) i_sqg_chk (.ref_clk(ref_clk),
  .nrst(nrst), .disp_pol(disp_pol), .led_red(led_red),
  .led_green(led_green), .led_yellow(led_yellow), .led_blue(led_blue),
  .digit1(digit1), .digit2(digit2), .seg(seg), .seg_oe(seg_oe));

// [test/sqg_board.sv]
// Purpose: button and display board beside the game
// Assumes: one press at a time, requested by the bench
// Notes: decodes both digits back to active high segments
`timescale 1ns/1ps
module sqg_board (
  input wire ref_clk,
  input wire go,
  input wire [3:0] mask,
  input wire [7:0] hold,
  input wire disp_pol,
  input wire digit1,
  input wire digit2,
  input wire [6:0] seg,
  output reg [3:0] btn,
  output reg busy,
  output reg [6:0] tens,
  output reg [6:0] ones
);
  reg [7:0] cnt_reg;
  initial begin
    btn = 4'h0;
    busy = 1'b0;
    tens = 7'h00;
    ones = 7'h00;
    cnt_reg = 8'h00;
  end
  // Hold the buttons, then leave a released gap
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      btn <= mask;
      cnt_reg <= hold;
      busy <= 1'b1;
    end else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
    else if (btn != 4'h0) begin
      btn <= 4'h0;
      cnt_reg <= 8'd40;
    end else
      busy <= 1'b0;
  end
  // Latch each digit while its select is active
  always @(posedge ref_clk) begin
    if (digit1 ^ disp_pol) tens <= seg ^ {7{disp_pol}};
    if (digit2 ^ disp_pol) ones <= seg ^ {7{disp_pol}};
  end
endmodule // sqg_board

// [test/tb_sqg_top.sv]
// Purpose: self-checking bench for the rule guessing game
// Assumes: shortened timing parameters; presses via the board
// Notes: expectations from a model of buffer and level
`timescale 1ns/1ps
`include "sqg_regs.vh"
module tb_sqg_top;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg disp_pol = 1'b0;
  reg go = 1'b0;
  reg [3:0] mask = 4'h0;
  reg [7:0] hold = 8'h00;
  reg [13:0] sq = 14'h0000;
  reg [2:0] len = 3'd0;
  reg [4:0] lvl = 5'd0;
  wire [3:0] btn;
  wire [6:0] seg, seg_oe, ones, tens;
  wire busy, led_red, led_green, led_yellow, led_blue;
  wire speaker, digit1, digit2;
  wire [6:0] leds = {3'd0, led_red, led_green, led_yellow, led_blue};
  integer failures = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer spk = 0;
  integer i, n;
  // Clock of 50 ns period
  always #25 ref_clk = ~ref_clk;
  sqg_top #(.DEB_CYC(24'd4), .LONG_CYC(24'd64), .FLASH_CYC(24'd8),
    .MUX_CYC(24'd4), .TONE_CYC(24'd4)) i_sqg_top (.ref_clk(ref_clk),
    .nrst(nrst), .btn_red(btn[0]), .btn_green(btn[1]),
    .btn_blue(btn[2]), .btn_yellow(btn[3]), .disp_pol(disp_pol),
    .led_red(led_red), .led_green(led_green), .led_yellow(led_yellow),
    .led_blue(led_blue), .speaker(speaker), .digit1(digit1),
    .digit2(digit2), .seg(seg), .seg_oe(seg_oe));
  sqg_board i_sqg_board (.ref_clk(ref_clk), .go(go), .mask(mask),
    .hold(hold), .disp_pol(disp_pol), .digit1(digit1),
    .digit2(digit2), .seg(seg), .btn(btn), .busy(busy), .tens(tens),
    .ones(ones));
  // Expected LED view of the buffer at the current level
  function automatic [6:0] exp_led();
    reg v;
    integer k;
    begin
      v = 1'b0;
      for (k = 0; k < 7; k = k + 1)
        if (k < len && sq[2*k+:2] == `SQG_C_RED) v = 1'b1;
      if (lvl == 5'd1) v = (sq[1:0] == `SQG_C_GREEN);
      exp_led = {3'd0, len != 0 && !v, len != 0 && v, len == 7, len == 0};
    end
  endfunction
  task chk(input [63:0] name, input [6:0] e, input [6:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", name, e, g);
      end
    end
  endtask
  // One press through the board, then a settle gap for flashes
  task press(input [3:0] m, input [7:0] h);
    begin
      @(posedge ref_clk);
      mask <= m;
      hold <= h;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      while (busy === 1'b1) @(posedge ref_clk);
      repeat (250) @(posedge ref_clk);
    end
  endtask
  task press_col(input [1:0] c);
    begin
      press(4'h1 << c, 8'd20);
      if (len < 3'd7) begin
        sq[2*len+:2] = c;
        len = len + 3'd1;
      end
      chk("leds", exp_led(), leds);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Count speaker edges
  always @(posedge speaker) spk = spk + 1;
  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      failures = failures + 1;
      final_report;
    end
  end
  // Main sequence
  initial begin
    n = $urandom(32'h0c63cb72);
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk("leds", 7'h01, leds);
    chk("ones", 7'h06, ones);
    chk("tens", 7'h00, tens);
    for (i = 0; i < 8; i = i + 1)
      press_col(2'($urandom % 4));
    press(`SQG_M_YELLOW, 8'd100);
    len = len - 3'd1;
    chk("leds", exp_led(), leds);
    press(`SQG_M_BLUE, 8'd100);
    chk("leds", exp_led(), leds);
    press(`SQG_M_RED, 8'd100);
    len = 3'd0;
    chk("leds", 7'h01, leds);
    press(`SQG_M_GREEN | `SQG_M_YELLOW, 8'd20);
    chk("valid", 7'h01, {5'd0, led_red, led_green});
    press(`SQG_M_RED | `SQG_M_BLUE, 8'd20);
    chk("valid", 7'h02, {5'd0, led_red, led_green});
    press(`SQG_M_RED, 8'd100);
    press(`SQG_M_GREEN | `SQG_M_BLUE, 8'd20);
    n = spk;
    press_col(`SQG_C_RED);
    chk("sound", 7'h00, {6'd0, spk != n});
    press(`SQG_M_GREEN | `SQG_M_BLUE, 8'd20);
    n = spk;
    press_col(`SQG_C_RED);
    chk("sound", 7'h01, {6'd0, spk != n});
    press(`SQG_M_RED, 8'd100);
    len = 3'd0;
    disp_pol <= 1'b1;
    press(`SQG_M_BLUE | `SQG_M_YELLOW, 8'd20);
    lvl = 5'd1;
    chk("ones", 7'h5b, ones);
    chk("leds", 7'h01, leds);
    disp_pol <= 1'b0;
    press_col(`SQG_C_GREEN);
    for (i = 0; i < 2; i = i + 1) begin
      press(`SQG_M_RED | `SQG_M_GREEN, 8'd20);
      chk("ones", 7'h06, ones);
    end
    lvl = 5'd0;
    press(`SQG_M_RED, 8'd100);
    len = 3'd0;
    press(`SQG_M_GREEN, 8'd100);
    chk("leds", 7'h00, leds);
    press(`SQG_M_BLUE | `SQG_M_YELLOW, 8'd20);
    press(`SQG_M_BLUE | `SQG_M_YELLOW, 8'd20);
    chk("tens", 7'h03, tens);
    press(`SQG_M_RED | `SQG_M_GREEN, 8'd20);
    chk("tens", 7'h01, tens);
    press(`SQG_M_BLUE, 8'd20);
    chk("tens", 7'h01, tens);
    chk("leds", 7'h00, leds);
    press(`SQG_M_RED | `SQG_M_YELLOW, 8'd20);
    chk("leds", 7'h01, leds);
    chk("ones", 7'h06, ones);
    press(`SQG_M_GREEN, 8'd100);
    for (i = 0; i < 15; i = i + 1) begin
      if (i == 14) chk("bar", 7'h7f, ones);
      press(`SQG_M_BLUE | `SQG_M_YELLOW, 8'd20);
    end
    chk("ones", 7'h5b, ones);
    chk("leds", 7'h01, leds);
    final_report;
  end
endmodule // tb_sqg_top
